/* File: core/tvs_params.svh */
`ifndef TVS_PARAMS_SVH
`define TVS_PARAMS_SVH
// ----------------------------------------
// register word indexes (address bits 5:2)
// ----------------------------------------
`define TVS_OFF_FLAG   4'h0
`define TVS_OFF_MASK   4'h1
`define TVS_OFF_PSW    4'h2
`define TVS_OFF_LAST   4'h3
// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define TVS_F_NONMASK  0
`define TVS_F_STKOV    1
`define TVS_F_STKUN    2
`define TVS_F_B_LO     3
`define TVS_F_B_HI     7
// ----------------------------------------
// reset values
// ----------------------------------------
`define TVS_FLAG_RST   8'h00
`define TVS_MASK_RST   8'h00
`define TVS_PSW_RST    5'h00
// ----------------------------------------
// trap numbers; an entry is four bytes
// ----------------------------------------
`define TVS_VEC_SHIFT  2
`define TVS_RESET_NUM  7'h00
`define TVS_NONMASK    7'h02
`define TVS_STKOV_NUM  7'h04
`define TVS_STKUN_NUM  7'h06
`define TVS_CLASSB     7'h0a
`define TVS_SW_LAST    24'h0001fc
`define TVS_EXT_BASE   7'h18
`define TVS_TMR_BASE   7'h22
`define TVS_ASC_TX     7'h2a
`define TVS_ASC_TB     7'h47
`define TVS_SER_BASE   7'h2b
`define TVS_XP_BASE    7'h40
`define TVS_NODES      28
`endif

/* File: core/tvs_pkg.sv */
`default_nettype none
package tvs_pkg;
    typedef enum logic [4:0] {
        TVS_K_RESET = 5'h01,
        TVS_K_A     = 5'h02,
        TVS_K_B     = 5'h04,
        TVS_K_SW    = 5'h08,
        TVS_K_IRQ   = 5'h10
    } tvs_kind_type;
    typedef struct packed {
        tvs_kind_type kind;
        logic [6:0]   num;
        logic [23:0]  addr;
        logic [3:0]   prio;
    } tvs_vec_type;
    typedef struct packed {
        logic       ien;
        logic [3:0] prio;
    } tvs_psw_type;
    typedef struct packed {
        logic       hit;
        logic [4:0] idx;
        logic [3:0] lvl;
    } tvs_pick_type;
endpackage : tvs_pkg
`default_nettype wire

/* File: core/tvs_trap_vector_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tvs_params.svh"

// Behaviour
// - every vector address is the trap number times four.
// - after any reset execution starts at vector address zero.
// - a reset outranks every trap and interrupt.
// - software traps accept numbers 00 to 7f, vectors up to 1fc.
// - a software trap keeps the current cpu priority unchanged.
// - class A traps use trap numbers 02, 04 and 06 with own flags.
// - all five class B traps share trap number 0a, each own flag.
// - traps seen in one instruction are served by fixed priority.
// - each interrupt node has its own fixed trap number 18 to 47.
// - a software trap vector comes from its seven-bit operand.
// - software tells class B causes apart by the flag register.
// - an interrupt is served only above the current cpu priority.
module tvs_trap_vector_select
    import tvs_pkg::*;
#(
    parameter logic [`TVS_NODES-1:0] NODE_EN = '1
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // avalon-mm slave
    input  wire logic [5:0]              avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [31:0]             avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic      [31:0]             avs_readdata_o,
    output logic                         avs_waitrequest_o,
    output logic                         irq_o,
    // reset sources
    input  wire logic                    sw_reset_i,
    input  wire logic                    wdt_overflow_i,
    // trap conditions
    input  wire logic                    nonmask_n_i,
    input  wire logic [7:1]              core_trap_i,
    // instruction sequencer
    input  wire logic                    instr_end_i,
    input  wire logic                    sw_trap_i,
    input  wire logic [6:0]              sw_trap_num_i,
    // interrupt nodes
    input  wire logic [`TVS_NODES-1:0]   int_req_i,
    input  wire logic [`TVS_NODES*4-1:0] int_lvl_i,
    // vector out
    output tvs_vec_type                  vec_o,
    output logic                         vec_valid_o,
    output logic      [`TVS_NODES-1:0]   node_ack_o,
    output logic      [3:0]              cpu_prio_o
);
    localparam int N = `TVS_NODES;

    // ----------------------------------------
    // decode functions
    // ----------------------------------------
    function automatic tvs_pick_type pick(input logic [N-1:0] req,
                                          input logic [N*4-1:0] lvl);
        tvs_pick_type p;
        p = '0;
        // strict compare: equal levels go to the lowest node index
        for (int i = 0; i < N; i++) begin
            if (req[i] && (!p.hit || lvl[i*4 +: 4] > p.lvl)) begin
                p.hit = 1'b1;
                p.idx = 5'(i);
                p.lvl = lvl[i*4 +: 4];
            end
        end
        return p;
    endfunction : pick

    function automatic logic [6:0] node_num(input logic [4:0] i);
        logic [6:0] n;
        n = `TVS_EXT_BASE;
        if (i < 5'h08) begin
            n = `TVS_EXT_BASE + 7'(i);
        end else if (i < 5'h0e) begin
            n = `TVS_TMR_BASE + 7'(i - 5'h08);
        end else if (i == 5'h0e) begin
            n = `TVS_ASC_TX;
        end else if (i == 5'h0f) begin
            n = `TVS_ASC_TB;
        end else if (i < 5'h15) begin
            n = `TVS_SER_BASE + 7'(i - 5'h10);
        end else begin
            n = `TVS_XP_BASE + 7'(i - 5'h15);
        end
        return n;
    endfunction : node_num

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic              nm_s1_reg;
    logic              nm_s2_reg;
    logic              nm_s3_reg;
    logic [7:0]        flag_reg;
    logic [7:0]        mask_reg;
    tvs_psw_type       psw_reg;
    logic [2:0]        pend_a_reg;
    logic              pend_b_reg;
    logic              rst_pend_reg;
    logic              sw_pend_reg;
    logic [6:0]        sw_num_reg;
    logic [11:0]       last_reg;
    logic              wait_reg;
    logic [31:0]       rdata_reg;
    logic              irq_reg;
    tvs_vec_type       vec_reg;
    logic              valid_reg;
    logic [N-1:0]      ack_reg;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire logic [3:0] widx    = avs_address_i[5:2];
    wire logic       wr_fire = avs_write_i & ~wait_reg
                               & avs_byteenable_i[0];
    wire logic       wr_flag = wr_fire & (widx == `TVS_OFF_FLAG);
    wire logic       wr_mask = wr_fire & (widx == `TVS_OFF_MASK);
    wire logic       wr_psw  = wr_fire & (widx == `TVS_OFF_PSW);
    wire logic [31:0] rd_mux =
        (widx == `TVS_OFF_FLAG) ? {24'h0, flag_reg} :
        (widx == `TVS_OFF_MASK) ? {24'h0, mask_reg} :
        (widx == `TVS_OFF_PSW)  ? {27'h0, psw_reg}  :
        (widx == `TVS_OFF_LAST) ? {20'h0, last_reg} : 32'h0;

    // ----------------------------------------
    // trap detection
    // ----------------------------------------
    // pin is active low; an edge, not a level, raises the trap
    wire logic       nm_fall = nm_s3_reg & ~nm_s2_reg;
    wire logic [7:0] hw_evt  = {core_trap_i, nm_fall};
    wire logic [7:0] flag_clr = wr_flag ? avs_writedata_i[7:0] : 8'h0;
    // set wins over a clear in the same cycle
    wire logic [7:0] flag_next = (flag_reg & ~flag_clr) | hw_evt;
    // traps caught in this instruction count as pending now
    wire logic [2:0] pa = pend_a_reg | hw_evt[`TVS_F_STKUN:0];
    wire logic       pb = pend_b_reg
                          | (|hw_evt[`TVS_F_B_HI:`TVS_F_B_LO]);

    // ----------------------------------------
    // dispatch selection
    // ----------------------------------------
    wire logic        go       = instr_end_i & ~rst_pend_reg;
    wire logic        sw_vis   = sw_pend_reg | sw_trap_i;
    wire logic [6:0]  sw_num   = sw_pend_reg ? sw_num_reg
                                             : sw_trap_num_i;
    wire tvs_pick_type best    = pick(int_req_i & NODE_EN, int_lvl_i);
    wire logic        irq_ok   = best.hit & psw_reg.ien
                                 & (best.lvl > psw_reg.prio);
    wire logic        take_rst = rst_pend_reg;
    wire logic        take_a   = go & (|pa);
    wire logic        take_b   = go & ~(|pa) & pb;
    wire logic        hw_any   = (|pa) | pb;
    wire logic        take_sw  = go & ~hw_any & sw_vis;
    wire logic        take_irq = go & ~hw_any & ~sw_vis & irq_ok;
    wire logic        any_take = take_rst | take_a | take_b
                                 | take_sw | take_irq;
    // class A: the non-maskable trap is served before the stack traps
    wire logic [2:0]  a_one    = pa[0] ? 3'h1 : (pa[1] ? 3'h2 : 3'h4);
    wire logic [6:0]  a_num    = pa[0] ? `TVS_NONMASK
                               : (pa[1] ? `TVS_STKOV_NUM
                                        : `TVS_STKUN_NUM);
    wire logic [6:0]  sel_num  =
        take_rst ? `TVS_RESET_NUM :
        take_a   ? a_num :
        take_b   ? `TVS_CLASSB :
        take_sw  ? sw_num : node_num(best.idx);
    wire tvs_kind_type sel_kind =
        take_rst ? TVS_K_RESET :
        take_a   ? TVS_K_A :
        take_b   ? TVS_K_B :
        take_sw  ? TVS_K_SW : TVS_K_IRQ;
    // only an interrupt entry raises the priority; traps keep it
    wire logic [3:0]  sel_prio = take_irq ? best.lvl
                               : (take_rst ? 4'h0
                                           : psw_reg.prio);
    wire logic [23:0] sel_addr =
        24'({sel_num, `TVS_VEC_SHIFT'(0)});
    wire logic [N-1:0] ack_next = take_irq ? (N'(1) << best.idx) : '0;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        nm_s1_reg <= nonmask_n_i;
        nm_s2_reg <= nm_s1_reg;
        nm_s3_reg <= nm_s2_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0;
            flag_reg  <= `TVS_FLAG_RST;
            mask_reg  <= `TVS_MASK_RST;
            irq_reg   <= 1'b0;
        end else begin
            // one wait state: data and write land on the second cycle
            wait_reg <= ~((avs_read_i | avs_write_i) & wait_reg);
            if (avs_read_i & wait_reg) begin
                rdata_reg <= rd_mux;
            end
            flag_reg <= flag_next;
            if (wr_mask) begin
                mask_reg <= avs_writedata_i[7:0];
            end
            irq_reg <= |(flag_reg & mask_reg);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psw_reg <= `TVS_PSW_RST;
        end else if (take_rst | take_irq) begin
            psw_reg.prio <= sel_prio;
            psw_reg.ien  <= psw_reg.ien & ~take_rst;
        end else if (wr_psw) begin
            psw_reg <= avs_writedata_i[4:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_pend_reg <= 1'b1;
            pend_a_reg   <= 3'h0;
            pend_b_reg   <= 1'b0;
            sw_pend_reg  <= 1'b0;
            sw_num_reg   <= 7'h00;
        end else begin
            rst_pend_reg <= sw_reset_i | wdt_overflow_i;
            // a reset discards whatever trap was waiting
            pend_a_reg  <= take_rst ? 3'h0
                                    : pa & ~(take_a ? a_one : 3'h0);
            pend_b_reg  <= pb & ~take_b & ~take_rst;
            sw_pend_reg <= sw_vis & ~take_sw & ~take_rst;
            if (sw_trap_i & ~sw_pend_reg) begin
                sw_num_reg <= sw_trap_num_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vec_reg   <= '{TVS_K_RESET, 7'h00, 24'h0, 4'h0};
            valid_reg <= 1'b0;
            ack_reg   <= '0;
            last_reg  <= 12'h0;
        end else begin
            valid_reg <= any_take;
            ack_reg   <= ack_next;
            if (any_take) begin
                vec_reg  <= '{sel_kind, sel_num, sel_addr, sel_prio};
                last_reg <= {sel_kind, sel_num};
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign avs_readdata_o    = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign irq_o             = irq_reg;
    assign vec_o             = vec_reg;
    assign vec_valid_o       = valid_reg;
    assign node_ack_o        = ack_reg;
    assign cpu_prio_o        = psw_reg.prio;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_vec_times_four: assert property (
        vec_valid_o |-> vec_o.addr == 24'(vec_o.num) * 24'h4)
        else $error("vector address is not four times trap number");
    chk_reset_vector: assert property (
        vec_valid_o && vec_o.kind == TVS_K_RESET
        |-> vec_o.addr == 24'h0 && vec_o.num == 7'h00)
        else $error("reset did not select vector zero");
    chk_reset_first: assert property (
        (sw_reset_i || wdt_overflow_i)
        |=> ##1 vec_valid_o && vec_o.kind == TVS_K_RESET)
        else $error("reset event not dispatched first");
    chk_sw_range: assert property (
        vec_valid_o && vec_o.kind == TVS_K_SW
        |-> vec_o.addr <= `TVS_SW_LAST)
        else $error("software trap vector out of range");
    chk_sw_keeps_prio: assert property (
        take_sw |=> vec_o.prio == $past(psw_reg.prio)
                    && $stable(cpu_prio_o))
        else $error("software trap changed cpu priority");
    chk_class_a_num: assert property (
        take_a && pa[0] |=> vec_o.num == 7'h02
        && vec_o.kind == TVS_K_A)
        else $error("non-maskable trap took wrong vector");
    chk_class_a_stack: assert property (
        take_a && !pa[0]
        |=> vec_o.num == ($past(pa[1]) ? 7'h04 : 7'h06))
        else $error("stack trap took wrong vector");

    chk_reset_prio: assert property (
        take_rst |=> vec_o.kind == TVS_K_RESET && cpu_prio_o == 4'h0)
        else $error("reset dispatch did not clear cpu priority");

    chk_irq_ack: assert property (
        vec_valid_o && vec_o.kind == TVS_K_IRQ |-> $onehot(node_ack_o))
        else $error("interrupt dispatch without one node acknowledge");

    chk_class_b_num: assert property (
        vec_valid_o && vec_o.kind == TVS_K_B |-> vec_o.num == 7'h0a)
        else $error("class B trap took wrong vector");
    chk_hw_over_sw: assert property (
        go && (|pa) && sw_vis |=> vec_o.kind == TVS_K_A
        ##1 !vec_valid_o || vec_o.kind != TVS_K_IRQ)
        else $error("hardware trap lost priority");
    chk_node_num: assert property (
        vec_valid_o && vec_o.kind == TVS_K_IRQ
        |-> vec_o.num >= 7'h18 && vec_o.num <= 7'h47)
        else $error("interrupt node trap number out of table");
    chk_sw_operand: assert property (
        take_sw && !sw_pend_reg |=> vec_o.num == $past(sw_trap_num_i))
        else $error("software trap number not from operand");
    chk_irq_level: assert property (
        take_irq |=> vec_o.prio > $past(psw_reg.prio)
                     && cpu_prio_o == vec_o.prio)
        else $error("interrupt served at or below cpu priority");
    chk_flag_sticky: assert property (
        hw_evt != 8'h0 |=> (flag_reg & $past(hw_evt)) == $past(hw_evt))
        else $error("trap flag not set on detection");
    chk_flag_held: assert property (
        flag_reg[7] && !wr_flag |=> flag_reg[7])
        else $error("class B flag dropped without a clear");

endmodule : tvs_trap_vector_select
`default_nettype wire

/* File: dv/tvs_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// instruction sequencer of the cpu core
// ----------------------------------------
module tvs_core_model (
    // clock
    input  wire logic  clk_i,
    // sequencer outputs
    output logic       instr_end_o,
    output logic       sw_trap_o,
    output logic [6:0] sw_trap_num_o,
    output logic [7:1] core_trap_o
);
    initial begin
        instr_end_o   = 1'b0;
        sw_trap_o     = 1'b0;
        sw_trap_num_o = 7'h55;
        core_trap_o   = 7'h00;
    end
    // a large gap models a slow core; the operand toggles when not
    // qualified so a stale number can never pass for a real one
    task automatic instr(input logic sw, input logic [6:0] num,
                         input logic [7:1] traps, input int gap);
        repeat (gap) @(posedge clk_i);
        instr_end_o   <= 1'b1;
        sw_trap_o     <= sw;
        sw_trap_num_o <= sw ? num : ~sw_trap_num_o;
        core_trap_o   <= traps;
        @(posedge clk_i);
        instr_end_o   <= 1'b0;
        sw_trap_o     <= 1'b0;
        sw_trap_num_o <= ~sw_trap_num_o;
        core_trap_o   <= 7'h00;
    endtask : instr
endmodule : tvs_core_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tvs_params.svh"
module tb;
    import tvs_pkg::*;
    logic                      clk_i, rst_i, avs_read_i, avs_write_i;
    logic [5:0]                avs_address_i;
    logic [31:0]               avs_writedata_i, avs_readdata_o, rd;
    logic [3:0]                avs_byteenable_i, cpu_prio_o;
    logic                      avs_waitrequest_o, irq_o, vec_valid_o;
    logic                      sw_reset_i, wdt_overflow_i, nonmask_n_i;
    logic [7:1]                core_trap_i, t;
    logic                      instr_end_i, sw_trap_i;
    logic [6:0]                sw_trap_num_i;
    logic [`TVS_NODES-1:0]     int_req_i, node_ack_o;
    logic [`TVS_NODES*4-1:0]   int_lvl_i;
    tvs_vec_type               vec_o;
    int                        n_mismatch, n_compared, cycles;

    tvs_trap_vector_select DUT (.clk_i(clk_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
        .sw_reset_i(sw_reset_i), .wdt_overflow_i(wdt_overflow_i),
        .nonmask_n_i(nonmask_n_i), .core_trap_i(core_trap_i),
        .instr_end_i(instr_end_i), .sw_trap_i(sw_trap_i),
        .sw_trap_num_i(sw_trap_num_i), .int_req_i(int_req_i),
        .int_lvl_i(int_lvl_i), .vec_o(vec_o), .vec_valid_o(vec_valid_o),
        .node_ack_o(node_ack_o), .cpu_prio_o(cpu_prio_o));
    tvs_core_model core (.clk_i(clk_i), .instr_end_o(instr_end_i),
        .sw_trap_o(sw_trap_i), .sw_trap_num_o(sw_trap_num_i),
        .core_trap_o(core_trap_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // checking and reporting
    // ----------------------------------------
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic check_word(input string what, input logic [31:0] e,
                              input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check_word
    task automatic check_vec(input tvs_kind_type k, input logic [6:0] n,
                             input logic [3:0] p);
        int w;
        w = 0;
        do begin
            @(negedge clk_i);
            w++;
        end while (vec_valid_o !== 1'b1 && w < 8);
        check_word("vec_valid", 32'h1, {31'h0, vec_valid_o});
        check_word("vec_kind", {27'h0, k}, {27'h0, vec_o.kind});
        check_word("vec_num", {25'h0, n}, {25'h0, vec_o.num});
        check_word("vec_addr", {23'h0, n, 2'b00}, {8'h0, vec_o.addr});
        if (k == TVS_K_SW || k == TVS_K_IRQ)
            check_word("vec_prio", {28'h0, p}, {28'h0, vec_o.prio});
    endtask : check_vec
    task automatic no_vec();
        logic seen;
        seen = 1'b0;
        repeat (4) begin
            @(negedge clk_i);
            seen = seen | (vec_valid_o !== 1'b0);
        end
        check_word("no_dispatch", 32'h0, {31'h0, seen});
    endtask : no_vec
    // ----------------------------------------
    // avalon-mm master
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int w;
        w = 0;
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        do begin
            @(posedge clk_i);
            w++;
        end while (avs_waitrequest_o !== 1'b0 && w < 16);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus
    task automatic read_chk(input string what, input logic [5:0] a,
                            input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check_word(what, e, rd);
    endtask : read_chk
    function automatic logic [6:0] node_num(input int i);
        if (i < 8) return 7'h18 + 7'(i);
        if (i < 14) return 7'h22 + 7'(i - 8);
        if (i == 14) return 7'h2a;
        if (i == 15) return 7'h47;
        if (i < 21) return 7'h2b + 7'(i - 16);
        return 7'h40 + 7'(i - 21);
    endfunction : node_num
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {avs_read_i, avs_write_i, sw_reset_i, wdt_overflow_i} = 4'h0;
        {avs_address_i, avs_writedata_i} = '0;
        {int_req_i, int_lvl_i} = '0;
        {n_mismatch, n_compared, cycles} = '0;
        avs_byteenable_i = 4'hf;
        nonmask_n_i = 1'b1;
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        check_vec(TVS_K_RESET, 7'h00, 4'h0);
        read_chk("flags", 6'h00, 32'h0);
        read_chk("unmapped", 6'h3c, 32'h0);
        // both ends of the software trap range plus two inner numbers
        for (int i = 0; i < 4; i++) begin
            t = (i == 0) ? 7'h00 : (i == 1) ? 7'h05
                                 : (i == 2) ? 7'h40 : 7'h7f;
            core.instr(1'b1, t, 7'h0, 1 + 2 * i);
            check_vec(TVS_K_SW, t, 4'h0);
        end
        bus(1'b1, 6'h08, 32'h13);
        read_chk("psw", 6'h08, 32'h13);
        int_lvl_i <= {`TVS_NODES{4'h5}};
        int_req_i <= 28'h28;
        core.instr(1'b0, 7'h0, 7'h0, 1);
        check_vec(TVS_K_IRQ, 7'h1b, 4'h5);
        check_word("ack", 32'h8, {4'h0, node_ack_o});
        check_word("prio", 32'h5, {28'h0, cpu_prio_o});
        core.instr(1'b0, 7'h0, 7'h0, 1);
        no_vec();
        core.instr(1'b1, 7'h11, 7'h0, 1);
        check_vec(TVS_K_SW, 7'h11, 4'h5);
        int_lvl_i <= {`TVS_NODES{4'h1}};
        for (int i = 0; i < `TVS_NODES; i++) begin
            bus(1'b1, 6'h08, 32'h10);
            int_req_i <= 28'h1 << i;
            core.instr(1'b0, 7'h0, 7'h0, 1);
            check_vec(TVS_K_IRQ, node_num(i), 4'h1);
        end
        bus(1'b1, 6'h08, 32'h00);
        int_req_i <= 28'h1;
        core.instr(1'b0, 7'h0, 7'h0, 1);
        no_vec();
        int_req_i <= 28'h0;
        bus(1'b1, 6'h00, 32'hff);
        core.instr(1'b1, 7'h05, 7'b0000101, 3);
        check_vec(TVS_K_A, 7'h04, 4'h0);
        core.instr(1'b0, 7'h0, 7'h0, 1);
        check_vec(TVS_K_B, 7'h0a, 4'h0);
        core.instr(1'b0, 7'h0, 7'h0, 1);
        check_vec(TVS_K_SW, 7'h05, 4'h0);
        read_chk("flags", 6'h00, 32'h0a);
        bus(1'b1, 6'h00, 32'h02);
        read_chk("flags", 6'h00, 32'h08);
        for (int k = 2; k < 8; k++) begin
            bus(1'b1, 6'h00, 32'hff);
            t = 7'h0;
            t[k] = 1'b1;
            core.instr(1'b0, 7'h0, t, 1);
            check_vec(k == 2 ? TVS_K_A : TVS_K_B, k == 2 ? 7'h06 : 7'h0a,
                      4'h0);
            read_chk("flags", 6'h00, 32'h1 << k);
        end
        core.instr(1'b0, 7'h0, 7'b0000011, 1);
        check_vec(TVS_K_A, 7'h04, 4'h0);
        core.instr(1'b0, 7'h0, 7'h0, 1);
        check_vec(TVS_K_A, 7'h06, 4'h0);
        bus(1'b1, 6'h00, 32'hff);
        bus(1'b1, 6'h04, 32'h01);
        nonmask_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        core.instr(1'b0, 7'h0, 7'b0000001, 1);
        check_vec(TVS_K_A, 7'h02, 4'h0);
        core.instr(1'b0, 7'h0, 7'h0, 1);
        check_vec(TVS_K_A, 7'h04, 4'h0);
        read_chk("last", 6'h0c, 32'h104);
        nonmask_n_i <= 1'b1;
        check_word("irq", 32'h1, {31'h0, irq_o});
        bus(1'b1, 6'h04, 32'h00);
        read_chk("mask", 6'h04, 32'h00);
        check_word("irq", 32'h0, {31'h0, irq_o});
        bus(1'b1, 6'h04, 32'h01);
        bus(1'b1, 6'h00, 32'h01);
        read_chk("flags", 6'h00, 32'h02);
        check_word("irq", 32'h0, {31'h0, irq_o});
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, 6'h08, 32'h17);
            @(posedge clk_i);
            sw_reset_i     <= (s == 0);
            wdt_overflow_i <= (s == 1);
            @(posedge clk_i);
            sw_reset_i     <= 1'b0;
            wdt_overflow_i <= 1'b0;
            core.instr(1'b1, 7'h09, 7'b0000010, 0);
            check_vec(TVS_K_RESET, 7'h00, 4'h0);
            check_word("prio", 32'h0, {28'h0, cpu_prio_o});
        end
        give_verdict();
    end
endmodule : tb
`default_nettype wire
